//--- rtl/pcsr_cal_flag.v
`timescale 1ns/1ns
`include "pcsr_map.vh"
module pcsr_cal_flag (
	input wire hclk,
	input wire hresetn,
	input wire cal_start,
	input wire cal_busy,
	output reg cal_done,
	output wire done_rise
);
	reg busy_q;
	assign done_rise = busy_q & ~cal_busy & ~cal_start;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q <= 1'b0;
			cal_done <= 1'b0;
		end else begin
			busy_q <= cal_busy;
			if (cal_start)
				cal_done <= 1'b0;
			else if (done_rise)
				cal_done <= 1'b1;
		end
	end
endmodule

//--- rtl/pcsr_irq.v
`timescale 1ns/1ns
`include "pcsr_map.vh"
module pcsr_irq (
	input wire hclk,
	input wire hresetn,
	input wire [`PCSR_EV_W-1:0] events,
	input wire [`PCSR_EV_W-1:0] clr,
	input wire en_wr,
	input wire [`PCSR_EV_W-1:0] en_data,
	output reg [`PCSR_EV_W-1:0] status,
	output reg [`PCSR_EV_W-1:0] enable,
	output wire irq
);
	assign irq = |(status & enable);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= {`PCSR_EV_W{1'b0}};
			enable <= {`PCSR_EV_W{1'b0}};
		end else begin
			// a new event wins over a clear in the same cycle
			status <= (status & ~clr) | events;
			if (en_wr)
				enable <= en_data;
		end
	end
endmodule

//--- rtl/pcsr_map.vh
`ifndef PCSR_MAP_VH
`define PCSR_MAP_VH
// register indices; the byte address is the index times four
`define PCSR_IDX_LOCK 16'h3200
`define PCSR_IDX_OPER 16'h3201
`define PCSR_IDX_ACQ 16'h3202
`define PCSR_IDX_HIST0 16'h3203
`define PCSR_IDX_HIST1 16'h3204
`define PCSR_IDX_HIST2 16'h3205
`define PCSR_IDX_HIST3 16'h3206
`define PCSR_IDX_HIST4 16'h3207
`define PCSR_IDX_HIST5 16'h3208
`define PCSR_IDX_PTUB0 16'h3209
`define PCSR_IDX_PTUB1 16'h320A
`define PCSR_IDX_FTUB0 16'h320B
`define PCSR_IDX_FTUB1 16'h320C
`define PCSR_IDX_SLACT 16'h320D
`define PCSR_IDX_SLERR 16'h320E
`define PCSR_IDX_UPDATE 16'h3210
`define PCSR_IDX_IRQ_STAT 16'h3211
`define PCSR_IDX_IRQ_CLR 16'h3212
`define PCSR_IDX_IRQ_EN 16'h3213
// lock register fields
`define PCSR_LK_ALL 0
`define PCSR_LK_DPH 1
`define PCSR_LK_DFR 2
`define PCSR_LK_ALOCK 3
`define PCSR_LK_CBUSY 4
`define PCSR_LK_CDONE 5
// interrupt event bits
`define PCSR_EV_CDONE 0
`define PCSR_EV_ALL_UP 1
`define PCSR_EV_ALL_DOWN 2
`define PCSR_EV_SNAP 3
`define PCSR_EV_W 4
`define PCSR_RST_BYTE 8'h00
`define PCSR_RST_HIST 46'h0000_0000_0000
`endif

//--- rtl/pcsr_top.v
// Operation
// - The calibration-busy flag is high exactly while an analog loop calibration runs.
// - Lock bit 3 reads one while the analog loop is locked.
// - Lock bit 2 reads one while the digital loop is frequency locked.
// - Lock bit 1 reads one while the digital loop is phase locked.
// - Lock bit 0 is the AND of the analog lock and the digital phase lock.
// - The lock register is live and needs no update command before a read.
// - The 46-bit holdover word history spans six bytes, low byte first, top two bits zero.
// - The 12-bit phase detector tub spans two registers, upper nibble of the second zero.
// - The 12-bit frequency detector tub spans two registers, upper nibble of the second zero.
// - Bits 7 and 6 of the lock register read zero.
// - Snapshot registers capture fresh values on an update command issued before a read.
// - The active profile sits in operation bits 6 to 4 and keeps the last active one when idle.
`timescale 1ns/1ns
`include "pcsr_map.vh"
module pcsr_top (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire analog_loop_ch_one_cal_start,
	input wire analog_loop_ch_one_cal_busy,
	input wire analog_loop_ch_one_locked,
	input wire digital_loop_ch_one_freq_locked,
	input wire digital_loop_ch_one_phase_locked,
	input wire digital_loop_ch_one_active,
	input wire [2:0] digital_loop_ch_one_profile,
	input wire digital_loop_ch_one_ref_switch,
	input wire digital_loop_ch_one_holdover,
	input wire digital_loop_ch_one_freerun,
	input wire fast_acquisition_done,
	input wire fast_acquisition_active,
	input wire digital_loop_ch_one_slew_limit,
	input wire digital_loop_ch_one_freq_clamped,
	input wire digital_loop_ch_one_history_avail,
	input wire [45:0] holdover_word,
	input wire [11:0] phase_lock_detector_tub,
	input wire [11:0] frequency_lock_detector_tub,
	input wire [3:0] slew_active,
	input wire [3:0] slew_error,
	output wire irq
);
	// byte address of a register index
	function [15:0] reg_addr;
		input [15:0] idx;
		begin
			reg_addr = {idx[13:0], 2'b00};
		end
	endfunction

	function hit;
		input [15:0] a;
		input [15:0] idx;
		begin
			hit = (a == reg_addr(idx));
		end
	endfunction

	// address phase capture
	reg dp_valid;
	reg dp_write;
	reg [15:0] dp_addr;
	wire take = hsel & hready & htrans[1];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 16'h0000;
		end else begin
			dp_valid <= take;
			if (take) begin
				dp_write <= hwrite;
				dp_addr <= haddr[15:0];
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	wire wr_cyc = dp_valid & dp_write;
	wire rd_take = take & ~hwrite;

	// calibration tracking
	wire cal_done;
	wire cal_done_rise;
	pcsr_cal_flag u_cal (
		.hclk(hclk),
		.hresetn(hresetn),
		.cal_start(analog_loop_ch_one_cal_start),
		.cal_busy(analog_loop_ch_one_cal_busy),
		.cal_done(cal_done),
		.done_rise(cal_done_rise)
	);

	// live lock register, no update needed
	wire all_lock = analog_loop_ch_one_locked & digital_loop_ch_one_phase_locked;
	wire [7:0] lock_byte = {2'b00,
		cal_done,
		analog_loop_ch_one_cal_busy,
		analog_loop_ch_one_locked,
		digital_loop_ch_one_freq_locked,
		digital_loop_ch_one_phase_locked,
		all_lock};

	// update command: writing bit 0 of the update register
	wire upd = wr_cyc & hit(dp_addr, `PCSR_IDX_UPDATE) & hwdata[0];

	reg [2:0] last_profile;
	reg [7:0] snap_oper;
	reg [7:0] snap_acq;
	reg [45:0] snap_hist;
	reg [11:0] snap_ptub;
	reg [11:0] snap_ftub;
	reg [3:0] snap_slact;
	reg [3:0] snap_slerr;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			last_profile <= 3'h0;
		else if (digital_loop_ch_one_active)
			last_profile <= digital_loop_ch_one_profile;
	end

	wire [2:0] cur_profile = digital_loop_ch_one_active ? digital_loop_ch_one_profile
		: last_profile;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			snap_oper <= `PCSR_RST_BYTE;
			snap_acq <= `PCSR_RST_BYTE;
			snap_hist <= `PCSR_RST_HIST;
			snap_ptub <= 12'h000;
			snap_ftub <= 12'h000;
			snap_slact <= 4'h0;
			snap_slerr <= 4'h0;
		end else if (upd) begin
			snap_oper <= {1'b0, cur_profile, digital_loop_ch_one_active,
				digital_loop_ch_one_ref_switch, digital_loop_ch_one_holdover,
				digital_loop_ch_one_freerun};
			snap_acq <= {2'b00, fast_acquisition_done, fast_acquisition_active, 1'b0,
				digital_loop_ch_one_slew_limit, digital_loop_ch_one_freq_clamped,
				digital_loop_ch_one_history_avail};
			snap_hist <= holdover_word;
			snap_ptub <= phase_lock_detector_tub;
			snap_ftub <= frequency_lock_detector_tub;
			snap_slact <= slew_active;
			snap_slerr <= slew_error;
		end
	end

	// interrupts
	reg all_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			all_q <= 1'b0;
		else
			all_q <= all_lock;
	end

	wire [`PCSR_EV_W-1:0] events;
	assign events[`PCSR_EV_CDONE] = cal_done_rise;
	assign events[`PCSR_EV_ALL_UP] = all_lock & ~all_q;
	assign events[`PCSR_EV_ALL_DOWN] = ~all_lock & all_q;
	assign events[`PCSR_EV_SNAP] = upd;

	wire clr_wr = wr_cyc & hit(dp_addr, `PCSR_IDX_IRQ_CLR);
	wire en_wr = wr_cyc & hit(dp_addr, `PCSR_IDX_IRQ_EN);
	wire [`PCSR_EV_W-1:0] irq_status;
	wire [`PCSR_EV_W-1:0] irq_enable;

	pcsr_irq u_irq (
		.hclk(hclk),
		.hresetn(hresetn),
		.events(events),
		.clr(clr_wr ? hwdata[`PCSR_EV_W-1:0] : {`PCSR_EV_W{1'b0}}),
		.en_wr(en_wr),
		.en_data(hwdata[`PCSR_EV_W-1:0]),
		.status(irq_status),
		.enable(irq_enable),
		.irq(irq)
	);

	// read mux; writes to status addresses fall through with no effect
	reg [7:0] rd_byte;
	always @* begin
		rd_byte = 8'h00;
		case (haddr[15:0])
		reg_addr(`PCSR_IDX_LOCK): rd_byte = lock_byte;
		reg_addr(`PCSR_IDX_OPER): rd_byte = snap_oper;
		reg_addr(`PCSR_IDX_ACQ): rd_byte = snap_acq;
		reg_addr(`PCSR_IDX_HIST0): rd_byte = snap_hist[7:0];
		reg_addr(`PCSR_IDX_HIST1): rd_byte = snap_hist[15:8];
		reg_addr(`PCSR_IDX_HIST2): rd_byte = snap_hist[23:16];
		reg_addr(`PCSR_IDX_HIST3): rd_byte = snap_hist[31:24];
		reg_addr(`PCSR_IDX_HIST4): rd_byte = snap_hist[39:32];
		reg_addr(`PCSR_IDX_HIST5): rd_byte = {2'b00, snap_hist[45:40]};
		reg_addr(`PCSR_IDX_PTUB0): rd_byte = snap_ptub[7:0];
		reg_addr(`PCSR_IDX_PTUB1): rd_byte = {4'h0, snap_ptub[11:8]};
		reg_addr(`PCSR_IDX_FTUB0): rd_byte = snap_ftub[7:0];
		reg_addr(`PCSR_IDX_FTUB1): rd_byte = {4'h0, snap_ftub[11:8]};
		reg_addr(`PCSR_IDX_SLACT): rd_byte = {4'h0, snap_slact};
		reg_addr(`PCSR_IDX_SLERR): rd_byte = {4'h0, snap_slerr};
		reg_addr(`PCSR_IDX_IRQ_STAT): rd_byte = {4'h0, irq_status};
		reg_addr(`PCSR_IDX_IRQ_EN): rd_byte = {4'h0, irq_enable};
		default: rd_byte = 8'h00;
		endcase
	end

	// read data registered at the address-phase edge; status writes are ignored
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (rd_take)
			hrdata <= {24'h000000, rd_byte};
	end
endmodule

//--- tb/pcsr_top_assertions.sv
`timescale 1ns/1ns
module pcsr_chk (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire analog_loop_ch_one_cal_busy,
	input wire analog_loop_ch_one_locked,
	input wire digital_loop_ch_one_freq_locked,
	input wire digital_loop_ch_one_phase_locked
);
	wire rd = hsel && hready && htrans[1] && !hwrite;
	wire lk = rd && haddr[15:0] == 16'hC800;
	wire [3:0] lkin = {analog_loop_ch_one_cal_busy, analog_loop_ch_one_locked,
		digital_loop_ch_one_freq_locked, digital_loop_ch_one_phase_locked};
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_lock; lk |=> hrdata[4:1] == $past(lkin); endproperty
	a_lock: assert property (p_lock) else $error("lock bits wrong");
	property p_all;
		lk |=> hrdata[0] == $past(analog_loop_ch_one_locked && digital_loop_ch_one_phase_locked);
	endproperty
	a_all: assert property (p_all) else $error("all lock wrong");
	property p_rsv; lk |=> hrdata[7:6] == 2'b00; endproperty
	a_rsv: assert property (p_rsv) else $error("lock reserved set");
	property p_hist; rd && haddr[15:0] == 16'hC820 |=> hrdata[7:6] == 2'b00; endproperty
	a_hist: assert property (p_hist) else $error("history top set");
	property p_ptub; rd && haddr[15:0] == 16'hC828 |=> hrdata[7:4] == 4'h0; endproperty
	a_ptub: assert property (p_ptub) else $error("phase tub top set");
	property p_ftub; rd && haddr[15:0] == 16'hC830 |=> hrdata[7:4] == 4'h0; endproperty
	a_ftub: assert property (p_ftub) else $error("freq tub top set");
	property p_up; hrdata[31:8] == 24'h0; endproperty
	a_up: assert property (p_up) else $error("upper read bits set");
	property p_hold; !rd |=> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_okay; hresp == 1'b0 && hreadyout == 1'b1; endproperty
	a_okay: assert property (p_okay) else $error("bus response wrong");
endmodule
bind pcsr_top pcsr_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata, .analog_loop_ch_one_cal_busy, .analog_loop_ch_one_locked,
	.digital_loop_ch_one_freq_locked, .digital_loop_ch_one_phase_locked);

//--- tb/pcsr_top_tb_top.sv
`timescale 1ns/1ns
module pcsr_top_tb_top;
	localparam [45:0] HW = 46'h2ABCDEF01234;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cs = 1'b0, cb = 1'b0;
	logic al = 1'b0, df = 1'b0, dp = 1'b0, ac = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [2:0] pf = 3'h0, ov = 3'h0;
	logic [4:0] sv = 5'h00;
	logic [3:0] sa = 4'h0, se = 4'h0;
	logic [11:0] pt = 12'h000, ft = 12'h000;
	logic [45:0] hw = 46'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
	wire hready, irq;
	wire [31:0] hrdata;
	int fail_count = 0, total_checks = 0, i;
	pcsr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(), .hrdata(hrdata), .analog_loop_ch_one_cal_start(cs),
		.analog_loop_ch_one_cal_busy(cb), .analog_loop_ch_one_locked(al),
		.digital_loop_ch_one_freq_locked(df), .digital_loop_ch_one_phase_locked(dp),
		.digital_loop_ch_one_active(ac), .digital_loop_ch_one_profile(pf),
		.digital_loop_ch_one_ref_switch(ov[2]), .digital_loop_ch_one_holdover(ov[1]),
		.digital_loop_ch_one_freerun(ov[0]), .fast_acquisition_done(sv[4]),
		.fast_acquisition_active(sv[3]), .digital_loop_ch_one_slew_limit(sv[2]),
		.digital_loop_ch_one_freq_clamped(sv[1]), .digital_loop_ch_one_history_avail(sv[0]),
		.holdover_word(hw), .phase_lock_detector_tub(pt), .frequency_lock_detector_tub(ft),
		.slew_active(sa), .slew_error(se), .irq(irq));
	task automatic print_verdict();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string n, input [31:0] s, input [31:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wt();
		for (int k = 0; k < 50; k++) begin
			@(posedge hclk);
			if (hready === 1'b1) return;
		end
		fail_count++;
		print_verdict();
	endtask
	task automatic bus(input [15:0] a, input w, input [31:0] d);
		haddr <= {16'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		wt();
		htrans <= 2'b00;
		hwdata <= d;
		wt();
		r = hrdata;
	endtask
	task automatic rd(input [15:0] a, input [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk($sformatf("reg %h", a), r, e);
	endtask
	initial forever #10 hclk = ~hclk;
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		hsel <= 1'b1;
		rd(16'hC84C, 32'h0);
		cs <= 1'b1;
		for (i = 0; i < 16; i++) begin
			{cb, al, df, dp} <= i[3:0];
			rd(16'hC800, {27'h0, i[3:0], i[2] & i[0]});
		end
		chk("irq masked", 32'(irq), 32'h0);
		rd(16'hC844, 32'h6);
		bus(16'hC84C, 1'b1, 32'h1);
		cs <= 1'b0;
		@(posedge hclk);
		cb <= 1'b0;
		repeat (3) @(posedge hclk);
		rd(16'hC800, 32'h2F);
		chk("irq", 32'(irq), 32'h1);
		bus(16'hC848, 1'b1, 32'h1);
		@(posedge hclk);
		chk("irq cleared", 32'(irq), 32'h0);
		cs <= 1'b1;
		@(posedge hclk);
		rd(16'hC800, 32'h0F);
		hw <= HW;
		pt <= 12'hA5C;
		ft <= 12'h5A3;
		sa <= 4'h9;
		se <= 4'h6;
		ac <= 1'b1;
		pf <= 3'h5;
		ov <= 3'h5;
		sv <= 5'h1B;
		bus(16'hC840, 1'b1, 32'h1);
		hw <= ~HW;
		ac <= 1'b0;
		pf <= 3'h2;
		ov <= 3'h0;
		bus(16'hC80C, 1'b1, 32'hFF);
		for (i = 0; i < 6; i++) begin
			rd(16'hC80C + 16'(4 * i), {24'h0, 8'(HW >> (8 * i))});
		end
		rd(16'hC824, 32'h5C);
		rd(16'hC828, 32'h0A);
		rd(16'hC82C, 32'hA3);
		rd(16'hC830, 32'h05);
		rd(16'hC834, 32'h09);
		rd(16'hC838, 32'h06);
		rd(16'hC804, 32'h5D);
		rd(16'hC808, 32'h33);
		rd(16'hC850, 32'h0);
		bus(16'hC840, 1'b1, 32'h1);
		rd(16'hC804, 32'h50);
		rd(16'hC844, 32'hE);
		print_verdict();
	end
endmodule
